// *** fps_fault_protect.v ***
// Fault supervision: pump undervoltage, logic POR, overcurrent and stall detection
`timescale 1ns/10ps
`include "fps_defines.vh"
module fps_fault_protect #(
  parameter CW = `FPS_CNT_W,
  parameter NSW = 4,
  parameter RETRY_CYC = (`FPS_RETRY_NS / `FPS_CLK_PERIOD_NS)
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Mode and configuration
  input wire serial_mode_in,
  input wire enable_hiz_in,
  input wire enable_high_in,
  input wire [`FPS_DECAY_W-1:0] decay_sel_in,
  input wire overcurrent_deglitch_sel_in,
  input wire overcurrent_recovery_sel_in,
  input wire lockup_detect_enable_in,
  input wire lockup_report_sel_in,
  input wire torque_count_scale_en_in,
  input wire autotorque_en_in,
  input wire [CW-1:0] lockup_threshold_wr_in,
  input wire lockup_threshold_we_in,
  // Commands
  input wire clear_faults_cmd_in,
  input wire sleep_n_input_in,
  input wire lockup_learn_start_in,
  // Analog fault inputs
  input wire pump_uv_in,
  input wire logic_uv_in,
  input wire other_fault_in,
  input wire [NSW-1:0] ls_limit_in,
  input wire [NSW-1:0] hs_limit_in,
  // Back-EMF measurement
  input wire half_cycle_in,
  input wire [CW-1:0] offtime_diff_in,
  input wire motor_stalled_in,
  // Bridge and pump control
  output reg bridge_en_out,
  output reg pump_en_out,
  output reg autotorque_ceiling_out,
  output reg autotorque_floor_out,
  // Fault pin
  output reg fault_n_output_out,
  output reg fault_n_oe_out,
  // Status
  output reg summary_fault_out,
  output reg pump_undervoltage_flag_out,
  output reg logic_por_flag_out,
  output reg overcurrent_flag_out,
  output reg [NSW-1:0] lowside_overcurrent_flag_out,
  output reg [NSW-1:0] highside_overcurrent_flag_out,
  output reg lockup_diag_flag_out,
  output reg lockup_flag_out,
  output reg [CW-1:0] torque_count_out,
  output reg [CW-1:0] lockup_threshold_out,
  output reg lockup_learn_done_out,
  output reg clear_faults_cmd_out
);
  localparam OVERCURRENT_DEGLITCH_SEL_S_CYC = (`FPS_OVERCURRENT_DEGLITCH_SEL_SHORT_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS;
  localparam OVERCURRENT_DEGLITCH_SEL_L_CYC = (`FPS_OVERCURRENT_DEGLITCH_SEL_LONG_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS;
  localparam LS_IDLE = 2'd0;
  localparam LS_STEADY = 2'd1;
  localparam LS_STALL = 2'd2;

  reg sleep_d_r;
  reg logic_uv_d_r;
  reg [15:0] deg_cnt_r;
  reg oc_active_r;
  reg oc_shut_r;
  reg [31:0] retry_cnt_r;
  reg [1:0] ls_r;
  reg [7:0] lhc_r;
  reg [CW+7:0] lacc_r;
  reg [CW-1:0] steady_r;
  wire clr_ev;
  wire limit_any;
  wire stall_run;
  wire [CW-1:0] avg_w;
  wire avg_v;
  wire [15:0] deg_lim;
  wire [CW:0] mean_w;
  wire rep_fault;

  function [CW-1:0] scale_cnt;
    input [CW-1:0] raw;
    input en;
    begin
      if (en && raw < `FPS_SCALE_LIMIT)
        scale_cnt = raw << `FPS_SCALE_SHIFT;
      else
        scale_cnt = raw;
    end
  endfunction

  assign clr_ev = clear_faults_cmd_in | (sleep_d_r & ~sleep_n_input_in);
  assign limit_any = |ls_limit_in | |hs_limit_in;
  assign deg_lim = (serial_mode_in && overcurrent_deglitch_sel_in) ? OVERCURRENT_DEGLITCH_SEL_L_CYC[15:0] :
                   OVERCURRENT_DEGLITCH_SEL_S_CYC[15:0];
  assign stall_run = serial_mode_in && (decay_sel_in == `FPS_DECAY_RIPPLE) &&
                     lockup_detect_enable_in && !pump_uv_in && !oc_shut_r &&
                     !logic_uv_in && !other_fault_in;
  assign mean_w = {1'b0, steady_r} + {1'b0, avg_w};
  assign rep_fault = pump_uv_in | oc_shut_r | other_fault_in |
                     (lockup_flag_out & lockup_report_sel_in);

  fps_torque_avg #(
    .W(CW)
  ) u_avg (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sample_valid_in(half_cycle_in & stall_run),
    .sample_in(offtime_diff_in),
    .restart_in(~stall_run),
    .avg_out(avg_w),
    .avg_valid_out(avg_v)
  );

  always @(posedge clk_in) begin
    if (rst_in) begin
      sleep_d_r <= 1'b1;
      logic_uv_d_r <= 1'b0;
      deg_cnt_r <= 16'h0000;
      oc_active_r <= 1'b0;
      oc_shut_r <= 1'b0;
      retry_cnt_r <= 32'h0000_0000;
      ls_r <= LS_IDLE;
      lhc_r <= 8'h00;
      lacc_r <= {(CW+8){1'b0}};
      steady_r <= {CW{1'b0}};
      bridge_en_out <= 1'b0;
      pump_en_out <= 1'b0;
      autotorque_ceiling_out <= 1'b0;
      autotorque_floor_out <= 1'b0;
      fault_n_output_out <= 1'b0;
      fault_n_oe_out <= 1'b0;
      summary_fault_out <= 1'b0;
      pump_undervoltage_flag_out <= 1'b0;
      logic_por_flag_out <= 1'b0;
      overcurrent_flag_out <= 1'b0;
      lowside_overcurrent_flag_out <= {NSW{1'b0}};
      highside_overcurrent_flag_out <= {NSW{1'b0}};
      lockup_diag_flag_out <= 1'b0;
      lockup_flag_out <= 1'b0;
      torque_count_out <= {CW{1'b0}};
      lockup_threshold_out <= {CW{1'b0}};
      lockup_learn_done_out <= 1'b0;
      clear_faults_cmd_out <= 1'b0;
    end else begin
      sleep_d_r <= sleep_n_input_in;
      logic_uv_d_r <= logic_uv_in;
      clear_faults_cmd_out <= 1'b0;
      // Overcurrent deglitch
      if (!limit_any)
        deg_cnt_r <= 16'h0000;
      else if (deg_cnt_r < deg_lim)
        deg_cnt_r <= deg_cnt_r + 16'h0001;
      oc_active_r <= limit_any && (deg_cnt_r >= deg_lim);
      // Overcurrent shutdown and recovery
      if (oc_active_r) begin
        oc_shut_r <= 1'b1;
        retry_cnt_r <= 32'h0000_0000;
      end else if (oc_shut_r) begin
        if (clr_ev)
          oc_shut_r <= 1'b0;
        else if ((serial_mode_in && overcurrent_recovery_sel_in) ||
                 (!serial_mode_in && enable_high_in && !enable_hiz_in)) begin
          if (retry_cnt_r >= RETRY_CYC - 1)
            oc_shut_r <= 1'b0;
          else
            retry_cnt_r <= retry_cnt_r + 32'h0000_0001;
        end
      end
      // Bridge and pump
      bridge_en_out <= !pump_uv_in && !logic_uv_in && !oc_shut_r && !oc_active_r;
      pump_en_out <= !logic_uv_in;
      // Torque count and stall
      if (avg_v) begin
        torque_count_out <= scale_cnt(avg_w, torque_count_scale_en_in);
      end
      // Sticky flags, fault event wins over clear; the logic POR flag is cleared at POR end and set by clear
      if (pump_uv_in && serial_mode_in)
        pump_undervoltage_flag_out <= 1'b1;
      else if (clr_ev)
        pump_undervoltage_flag_out <= 1'b0;
      if (logic_uv_d_r && !logic_uv_in && serial_mode_in)
        logic_por_flag_out <= 1'b0;
      else if (clr_ev)
        logic_por_flag_out <= 1'b1;
      if (oc_active_r && serial_mode_in) begin
        overcurrent_flag_out <= 1'b1;
        lowside_overcurrent_flag_out <= lowside_overcurrent_flag_out | ls_limit_in;
        highside_overcurrent_flag_out <= highside_overcurrent_flag_out | hs_limit_in;
      end else if (clr_ev) begin
        overcurrent_flag_out <= 1'b0;
        lowside_overcurrent_flag_out <= {NSW{1'b0}};
        highside_overcurrent_flag_out <= {NSW{1'b0}};
      end
      if (avg_v && stall_run && avg_w < lockup_threshold_out && ls_r == LS_IDLE) begin
        lockup_flag_out <= 1'b1;
        lockup_diag_flag_out <= 1'b1;
      end else if (clr_ev) begin
        lockup_flag_out <= 1'b0;
        lockup_diag_flag_out <= 1'b0;
      end
      if ((pump_uv_in || oc_active_r) && serial_mode_in)
        summary_fault_out <= 1'b1;
      else if (avg_v && stall_run && avg_w < lockup_threshold_out && ls_r == LS_IDLE)
        summary_fault_out <= 1'b1;
      else if (clr_ev)
        summary_fault_out <= pump_uv_in | oc_shut_r;
      // Fault pin, open drain active low
      fault_n_output_out <= 1'b0;
      fault_n_oe_out <= rep_fault && !logic_uv_in;
      // Auto-torque level selection
      autotorque_ceiling_out <= autotorque_en_in && lockup_detect_enable_in &&
                                lockup_flag_out;
      autotorque_floor_out <= autotorque_en_in && !lockup_detect_enable_in &&
                              motor_stalled_in;
      // Threshold learning
      case (ls_r)
        LS_IDLE: begin
          if (lockup_threshold_we_in)
            lockup_threshold_out <= lockup_threshold_wr_in;
          if (lockup_learn_start_in) begin
            ls_r <= LS_STEADY;
            lhc_r <= 8'h00;
            lacc_r <= {(CW+8){1'b0}};
            lockup_learn_done_out <= 1'b0;
          end
        end
        LS_STEADY: begin
          if (avg_v) begin
            lhc_r <= lhc_r + 8'h01;
            steady_r <= avg_w;
            if (lhc_r == `FPS_LEARN_STEADY_HC - 8'h01) begin
              ls_r <= LS_STALL;
              lhc_r <= 8'h00;
            end
          end
        end
        LS_STALL: begin
          if (avg_v) begin
            lhc_r <= lhc_r + 8'h01;
            if (lhc_r == `FPS_LEARN_STALL_HC - 8'h01) begin
              ls_r <= LS_IDLE;
              if (avg_w < steady_r) begin
                lockup_threshold_out <= mean_w[CW:1];
                lockup_learn_done_out <= 1'b1;
              end
            end
          end
        end
        default: ls_r <= LS_IDLE;
      endcase
    end
  end
endmodule // fps_fault_protect

// *** fps_defines.vh ***
// Shared constants for the fault supervision and stall detection block
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH
`define FPS_CNT_W 16
`define FPS_SCALE_LIMIT 16'h01F4
`define FPS_SCALE_SHIFT 3
`define FPS_DECAY_W 3
`define FPS_DECAY_RIPPLE 3'h7
`define FPS_LEARN_STEADY_HC 8'h40
`define FPS_LEARN_STALL_HC 8'h20
`define FPS_OVERCURRENT_DEGLITCH_SEL_SHORT_NS 1000
`define FPS_OVERCURRENT_DEGLITCH_SEL_LONG_NS 2000
`define FPS_RETRY_NS 4000000
`define FPS_CLK_PERIOD_NS 5
`endif

// *** fps_torque_avg.v ***
// Running average of the last four half-cycle torque samples
`timescale 1ns/10ps
module fps_torque_avg #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Sample input
  input wire sample_valid_in,
  input wire [W-1:0] sample_in,
  input wire restart_in,
  // Averaged output
  output reg [W-1:0] avg_out,
  output reg avg_valid_out
);
  reg [W-1:0] s0_r;
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  wire [W+1:0] sum_w;

  assign sum_w = {2'b00, sample_in} + {2'b00, s0_r} + {2'b00, s1_r} + {2'b00, s2_r};

  always @(posedge clk_in) begin
    if (rst_in || restart_in) begin
      s0_r <= {W{1'b0}};
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      avg_out <= {W{1'b0}};
      avg_valid_out <= 1'b0;
    end else begin
      avg_valid_out <= sample_valid_in;
      if (sample_valid_in) begin
        s2_r <= s1_r;
        s1_r <= s0_r;
        s0_r <= sample_in;
        avg_out <= sum_w[W+1:2];
      end
    end
  end
endmodule // fps_torque_avg

// *** fps_motor_model.sv ***
// Motor model giving one torque sample per electrical half-cycle
`timescale 1ns/10ps
module fps_motor_model (
  // Clock and control
  input wire clk_in,
  input wire run_in,
  input wire bridge_en_in,
  input wire [15:0] value_in,
  // Half-cycle samples
  output reg half_cycle_out = 1'b0,
  output reg [15:0] sample_out = 16'h0000
);
  reg [2:0] ph_r = 3'h0;
  // Steps every cycle; pulses only while running and the bridge drives; sample line toggles between pulses
  always @(negedge clk_in) begin
    ph_r <= ph_r + 3'h1;
    half_cycle_out <= run_in && bridge_en_in && (ph_r == 3'h7);
    sample_out <= (ph_r == 3'h7) ? value_in : ~sample_out;
  end
endmodule // fps_motor_model

// *** fps_checker.sv ***
// Assertion checker for the fault supervision block
`timescale 1ns/10ps
module fps_checker #(parameter NSW = 4) (
  // Clock, reset and watched inputs
  input wire clk_in,
  input wire rst_in,
  input wire [2:0] decay_sel_in,
  input wire overcurrent_deglitch_sel_in,
  input wire lockup_detect_enable_in,
  input wire lockup_report_sel_in,
  input wire autotorque_en_in,
  input wire clear_faults_cmd_in,
  input wire pump_uv_in,
  input wire logic_uv_in,
  input wire [NSW-1:0] ls_limit_in,
  input wire [NSW-1:0] hs_limit_in,
  input wire half_cycle_in,
  // Watched outputs
  input wire bridge_en_out,
  input wire pump_en_out,
  input wire autotorque_ceiling_out,
  input wire fault_n_oe_out,
  input wire pump_undervoltage_flag_out,
  input wire logic_por_flag_out,
  input wire overcurrent_flag_out,
  input wire lockup_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg [9:0] lim_cnt_r;
  // Cycles the current limit has lasted
  always @(posedge clk_in) begin
    if (rst_in || ({ls_limit_in, hs_limit_in} == 0)) lim_cnt_r <= 10'h000;
    else if (lim_cnt_r != 10'h3FF) lim_cnt_r <= lim_cnt_r + 10'h001;
  end
  pump_uv_a: assert property (pump_uv_in [*4] |->
    pump_undervoltage_flag_out && fault_n_oe_out && !bridge_en_out) else $error("pump uv");
  logic_uv_a: assert property (logic_uv_in [*3] |-> !pump_en_out && !bridge_en_out)
    else $error("logic uv");
  ocp_long_a: assert property (lim_cnt_r == 10'h19A |-> overcurrent_flag_out)
    else $error("overcurrent late");
  ocp_short_a: assert property (!overcurrent_deglitch_sel_in && lim_cnt_r == 10'h0CD |->
    overcurrent_flag_out) else $error("short deglitch");
  ocp_early_a: assert property ($rose(overcurrent_flag_out) |->
    lim_cnt_r >= (overcurrent_deglitch_sel_in ? 10'h18F : 10'h0C7)) else $error("ocp early");
  stall_gate_a: assert property ($rose(lockup_flag_out) |->
    $past(decay_sel_in == 3'h7 && lockup_detect_enable_in, 3) &&
    ($past(half_cycle_in, 2) || $past(half_cycle_in, 3))) else $error("stall gate");
  stall_rep_a: assert property ((lockup_flag_out && lockup_report_sel_in) [*2] |->
    fault_n_oe_out) else $error("stall report");
  torque_max_a: assert property ((lockup_flag_out && lockup_detect_enable_in &&
    autotorque_en_in) [*2] |-> autotorque_ceiling_out) else $error("ceiling");
  clear_evt_a: assert property (clear_faults_cmd_in && !pump_uv_in && !half_cycle_in &&
    !$past(half_cycle_in) ##1 !pump_uv_in |-> ##1 !pump_undervoltage_flag_out &&
    !lockup_flag_out) else $error("clear");
  por_set_a: assert property (clear_faults_cmd_in && !logic_uv_in && !$past(logic_uv_in) ##1
    !logic_uv_in |->
    ##1 logic_por_flag_out) else $error("por flag");
  cover property ($rose(lockup_flag_out));
  cover property (overcurrent_flag_out && bridge_en_out);
  cover property ($rose(logic_por_flag_out));
endmodule // fps_checker
bind fps_fault_protect fps_checker #(.NSW(NSW)) u_chk (.*);

// *** fps_fault_protect_tb.sv ***
// Self-checking bench for the fault supervision block
`timescale 1ns/10ps
module fps_fault_protect_tb;
  reg clk_in = 1'b0, rst_in = 1'b1, run_in = 1'b0;
  wire serial_mode_in = 1'b1, enable_hiz_in = 1'b0, enable_high_in = 1'b0, other_fault_in = 1'b0;
  reg [2:0] decay_sel_in = 3'h7;
  reg overcurrent_deglitch_sel_in = 1'b0, overcurrent_recovery_sel_in = 1'b0;
  reg lockup_detect_enable_in = 1'b0, lockup_report_sel_in = 1'b0, autotorque_en_in = 1'b0;
  reg torque_count_scale_en_in = 1'b0, lockup_threshold_we_in = 1'b0, motor_stalled_in = 1'b0;
  reg clear_faults_cmd_in = 1'b0, sleep_n_input_in = 1'b1, lockup_learn_start_in = 1'b0;
  reg pump_uv_in = 1'b0, logic_uv_in = 1'b0;
  reg [15:0] lockup_threshold_wr_in = 16'h0000, value_in = 16'h0000;
  reg [3:0] ls_limit_in = 4'h0, hs_limit_in = 4'h0;
  wire half_cycle_in, bridge_en_out, pump_en_out, autotorque_ceiling_out, autotorque_floor_out;
  wire fault_n_output_out, fault_n_oe_out, summary_fault_out, pump_undervoltage_flag_out;
  wire logic_por_flag_out, overcurrent_flag_out, lockup_diag_flag_out, lockup_flag_out;
  wire lockup_learn_done_out, clear_faults_cmd_out;
  wire [3:0] lowside_overcurrent_flag_out, highside_overcurrent_flag_out;
  wire [15:0] offtime_diff_in, torque_count_out, lockup_threshold_out;
  integer n_mismatch = 0, n_compared = 0, i;
  fps_fault_protect #(.RETRY_CYC(20)) u_dut (.*);
  fps_motor_model u_mot (.clk_in, .run_in, .bridge_en_in(bridge_en_out), .value_in,
    .half_cycle_out(half_cycle_in), .sample_out(offtime_diff_in));
  always #2.5 clk_in = ~clk_in;
  task wt(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  task cv(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cb(input string nm, input logic e, input logic g);
    cv(nm, 16'(e), 16'(g));
  endtask
  task clr;
    clear_faults_cmd_in = 1'b1;
    wt(1);
    clear_faults_cmd_in = 1'b0;
    wt(3);
  endtask
  task t_pump;
    pump_uv_in = 1'b1;
    wt(4);
    cb("pump_flag", 1'b1, pump_undervoltage_flag_out);
    cb("pump_en", 1'b1, pump_en_out);
    cb("pin_level", 1'b0, fault_n_output_out);
    pump_uv_in = 1'b0;
    wt(4);
    cb("bridge", 1'b1, bridge_en_out);
    cb("pump_flag", 1'b1, pump_undervoltage_flag_out);
    clr;
    cb("pump_flag", 1'b0, pump_undervoltage_flag_out);
    cb("clr_bit", 1'b0, clear_faults_cmd_out);
  endtask
  task t_por;
    logic_uv_in = 1'b1;
    wt(3);
    cb("oe_luv", 1'b0, fault_n_oe_out);
    logic_uv_in = 1'b0;
    wt(3);
    cb("pump_en", 1'b1, pump_en_out);
    cb("por", 1'b0, logic_por_flag_out);
    sleep_n_input_in = 1'b0;
    wt(1);
    sleep_n_input_in = 1'b1;
    wt(3);
    cb("por", 1'b1, logic_por_flag_out);
  endtask
  task t_ocp(input logic rc, input logic dg);
    overcurrent_recovery_sel_in = rc;
    overcurrent_deglitch_sel_in = dg;
    ls_limit_in = rc ? 4'h0 : 4'h2;
    hs_limit_in = rc ? 4'h4 : 4'h0;
    wt(dg ? 396 : 196);
    cb("ocp_early", 1'b0, overcurrent_flag_out);
    wt(16);
    cb("ocp", 1'b1, summary_fault_out);
    cb("bridge", 1'b0, bridge_en_out);
    cb("oe", 1'b1, fault_n_oe_out);
    cv("ls_flags", 16'(ls_limit_in), 16'(lowside_overcurrent_flag_out));
    cv("hs_flags", 16'(hs_limit_in), 16'(highside_overcurrent_flag_out));
    ls_limit_in = 4'h0;
    hs_limit_in = 4'h0;
    wt(40);
    cb("recover", rc, bridge_en_out);
    cb("ocp_held", 1'b1, overcurrent_flag_out);
    clr;
    cb("bridge", 1'b1, bridge_en_out);
  endtask
  task t_stall(input logic rep);
    lockup_report_sel_in = rep;
    autotorque_en_in = 1'b1;
    torque_count_scale_en_in = 1'b1;
    lockup_detect_enable_in = 1'b0;
    motor_stalled_in = 1'b1;
    lockup_threshold_wr_in = 16'h0064;
    lockup_threshold_we_in = 1'b1;
    wt(1);
    lockup_threshold_we_in = 1'b0;
    value_in = 16'h000A;
    run_in = 1'b1;
    wt(64);
    cb("stall_off", 1'b0, lockup_flag_out);
    cb("floor", 1'b1, autotorque_floor_out);
    value_in = 16'h0258;
    lockup_detect_enable_in = 1'b1;
    motor_stalled_in = 1'b0;
    wt(64);
    cv("count", 16'h0258, torque_count_out);
    cb("no_stall", 1'b0, lockup_flag_out);
    value_in = 16'h000A;
    wt(64);
    cb("stall", 1'b1, lockup_diag_flag_out);
    cb("stall_oe", rep, fault_n_oe_out);
    cb("ceiling", 1'b1, autotorque_ceiling_out);
    cv("count", 16'h0050, torque_count_out);
    run_in = 1'b0;
    wt(4);
    clr;
    cb("stall_clr", 1'b0, lockup_flag_out);
    cb("oe_clr", 1'b0, fault_n_oe_out);
  endtask
  task t_learn;
    lockup_detect_enable_in = 1'b1;
    torque_count_scale_en_in = 1'b0;
    value_in = 16'h0258;
    run_in = 1'b1;
    wt(40);
    lockup_learn_start_in = 1'b1;
    wt(1);
    lockup_learn_start_in = 1'b0;
    wt(540);
    value_in = 16'h00C8;
    for (i = 0; i < 600 && lockup_learn_done_out !== 1'b1; i = i + 1) wt(1);
    cb("learn_done", 1'b1, lockup_learn_done_out);
    if (lockup_learn_done_out !== 1'b1) end_sim;
    n_compared = n_compared + 1;
    if (lockup_threshold_out < 16'h018B || lockup_threshold_out > 16'h019F) begin
      n_mismatch = n_mismatch + 1;
      $display("FAIL learned_th expected 0190 seen %h", lockup_threshold_out);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    wt(3);
    rst_in = 1'b0;
    wt(2);
    t_pump;
    t_por;
    t_ocp(1'b0, 1'b0);
    t_ocp(1'b1, 1'b1);
    t_stall(1'b1);
    t_stall(1'b0);
    t_learn;
    end_sim;
  end
endmodule // fps_fault_protect_tb
